// ---- rtl/srtc_params.svh ----
// constants of the serial rtc register front end: offsets, fields, limits, timing
// assumes a 25 MHz system clock and a 32.768 kHz oscillator on its own clock port
`ifndef SRTC_PARAMS_SVH
`define SRTC_PARAMS_SVH

`define SRTC_SLAVE_ADDR 7'h68
`define SRTC_CLK_HZ 25000000
`define SRTC_BUF_NS 1300
`define SRTC_REC_MS 40
`define SRTC_REC_CYC (`SRTC_REC_MS * (`SRTC_CLK_HZ / 1000))
`define SRTC_TICK_DIV 16'h0148
`define SRTC_MEM_WORDS 64
`define SRTC_A_SUB 6'h00
`define SRTC_A_CLK_LAST 6'h07
`define SRTC_A_HT 6'h0c
`define SRTC_HT_BIT 6
`define SRTC_HALT_BIT 7
`define SRTC_CEN_EN_BIT 7
`define SRTC_CEN_BIT 6
`define SRTC_SUB_MAX 8'h99
`define SRTC_MIN_MAX 8'h59
`define SRTC_HOUR_MAX 8'h23
`define SRTC_WDAY_MAX 8'h07
`define SRTC_MON_MAX 8'h12
`define SRTC_YEAR_MAX 8'h99
`define SRTC_ONE 8'h01

`endif

// ---- rtl/srtc_pkg.sv ----
// types shared by the serial rtc front end
// assumes srtc_params.svh supplies the numeric constants
package srtc_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_ADDR = 4'b0001,
    S_AACK = 4'b0010,
    S_WORD = 4'b0011,
    S_WACK = 4'b0100,
    S_WDAT = 4'b0101,
    S_DACK = 4'b0110,
    S_RDAT = 4'b0111,
    S_RACK = 4'b1000,
    S_RNXT = 4'b1001,
    S_WAIT = 4'b1010
  } srtc_state_e;
endpackage : srtc_pkg

// ---- rtl/srtc_top.sv ----
// serial rtc: two-wire slave, 64-byte register space, live bcd time, supply deselect
// assumes comparator inputs for power fail and battery, oscillator on osc_clk_i
`include "srtc_params.svh"
module srtc_top #(
  parameter int unsigned REC_CYCLES = `SRTC_REC_CYC,
  parameter logic [15:0] TICK_DIV = `SRTC_TICK_DIV
) (
  // clocks and reset
  input wire logic sys_clk_i,
  input wire logic osc_clk_i,
  input wire logic rstn_i,
  // two-wire bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // supply supervision and bus state
  input wire logic pfail_i,
  input wire logic batt_i,
  output logic rst_n_o,
  output logic rst_oe_o,
  output srtc_pkg::srtc_state_e bus_state_o
);
  import srtc_pkg::*;

  srtc_state_e st_r;
  logic scl_q1, scl_q2, scl_q3, sda_q1, sda_q2, sda_q3;
  logic pf_q1, pf_s, pf_d_r, bat_q1, bat_s;
  logic tk_q1, tk_q2, tk_q3;
  logic ht_q1, ht_q2, tick_tgl_r;
  logic [15:0] div_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r, tx_r;
  logic [5:0] ptr_r;
  logic rw_r, in_xfer_r, sda_oe_r, sda_lo_r;
  logic [31:0] rec_cnt_r;
  logic rst_n_r, rst_oe_r;
  logic [7:0] lv_hund, lv_sec, lv_min, lv_hour, lv_wday, lv_date, lv_mon, lv_year;
  logic [7:0] mem_r [0:`SRTC_MEM_WORDS-1];
  logic [7:0] live_w [0:7];
  logic scl_rise, scl_fall, start_w, stop_w, tick, pf_rise, desel, wr_en, frozen, copy_en;
  logic [7:0] rd_byte;
  logic [7:0] h_n, s_n, m_n, hr_n, wd_n, dt_n, mo_n, yr_n;
  logic c0, c1, c2, c3, c4, c5, c6, cent_w;

  // returns {carry, next}; wraps to lo after hi
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] hi,
                                         input logic [7:0] lo);
    if (v == hi) begin
      bcd_inc = {1'b1, lo};
    end else if (v[3:0] == 4'h9) begin
      bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  // year 00 counts as leap: the century flag carries the rest
  function automatic logic [7:0] month_days(input logic [4:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      5'h02: month_days = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: month_days = 8'h30;
      default: month_days = 8'h31;
    endcase
  endfunction : month_days

  // oscillator domain: halt level crosses in, hundredths tick crosses out as a toggle
  always_ff @(posedge osc_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ht_q1 <= 1'b0;
      ht_q2 <= 1'b0;
    end else begin
      ht_q1 <= lv_sec[`SRTC_HALT_BIT];
      ht_q2 <= ht_q1;
    end
  end

  always_ff @(posedge osc_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_r <= 16'h0000;
      tick_tgl_r <= 1'b0;
    end else if (ht_q2) begin
      div_r <= 16'h0000;
    end else if (div_r == TICK_DIV - 16'h0001) begin
      div_r <= 16'h0000;
      tick_tgl_r <= ~tick_tgl_r;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  // pin and cross-domain synchronisers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {scl_q1, scl_q2, scl_q3} <= 3'h7;
      {sda_q1, sda_q2, sda_q3} <= 3'h7;
      {pf_q1, pf_s, pf_d_r, bat_q1, bat_s} <= 5'h00;
      {tk_q1, tk_q2, tk_q3} <= 3'h0;
    end else begin
      {scl_q1, scl_q2, scl_q3} <= {scl_i, scl_q1, scl_q2};
      {sda_q1, sda_q2, sda_q3} <= {sda_i, sda_q1, sda_q2};
      {pf_q1, pf_s, pf_d_r} <= {pfail_i, pf_q1, pf_s};
      {bat_q1, bat_s} <= {batt_i, bat_q1};
      {tk_q1, tk_q2, tk_q3} <= {tick_tgl_r, tk_q1, tk_q2};
    end
  end

  assign scl_rise = scl_q2 && !scl_q3;
  assign scl_fall = !scl_q2 && scl_q3;
  assign start_w = scl_q2 && scl_q3 && !sda_q2 && sda_q3;
  assign stop_w = scl_q2 && scl_q3 && sda_q2 && !sda_q3;
  assign tick = tk_q2 ^ tk_q3;
  assign pf_rise = pf_s && !pf_d_r;
  assign desel = pf_s || (rec_cnt_r != 32'h0);
  assign wr_en = (st_r == S_WDAT) && scl_fall && (cnt_r == 4'h8) && !desel;
  assign rd_byte = mem_r[ptr_r];
  assign frozen = (in_xfer_r && ptr_r <= `SRTC_A_CLK_LAST)
               || mem_r[`SRTC_A_HT][`SRTC_HT_BIT];
  assign copy_en = tick && !frozen;

  // supply supervision
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rec_cnt_r <= 32'h0;
    end else if (pf_s) begin
      rec_cnt_r <= REC_CYCLES;
    end else if (rec_cnt_r != 32'h0) begin
      rec_cnt_r <= rec_cnt_r - 32'h1;
    end
  end

  // open-drain reset: driven low while deselected, released on battery
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_n_r <= 1'b1;
      rst_oe_r <= 1'b0;
      sda_lo_r <= 1'b0;
    end else begin
      rst_n_r <= !desel;
      rst_oe_r <= desel && !bat_s;
      sda_lo_r <= 1'b0;
    end
  end

  // bus slave
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= S_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 6'h00;
      rw_r <= 1'b0;
      in_xfer_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (pf_s || bat_s) begin
      st_r <= S_IDLE;
      ptr_r <= 6'h00;
      in_xfer_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (desel) begin
      st_r <= S_IDLE;
      in_xfer_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (stop_w) begin
      st_r <= S_IDLE;
      in_xfer_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (start_w) begin
      st_r <= S_ADDR;
      cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else begin
      case (st_r)
        S_ADDR, S_WORD, S_WDAT: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_q2};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == 4'h8) begin
            sda_oe_r <= 1'b1;
            if (st_r == S_ADDR) begin
              if (sh_r[7:1] == `SRTC_SLAVE_ADDR) begin
                rw_r <= sh_r[0];
                in_xfer_r <= 1'b1;
                st_r <= S_AACK;
              end else begin
                sda_oe_r <= 1'b0;
                st_r <= S_WAIT;
              end
            end else if (st_r == S_WORD) begin
              ptr_r <= sh_r[5:0];
              st_r <= S_WACK;
            end else begin
              st_r <= S_DACK;
            end
          end
        end
        S_AACK, S_WACK: begin
          if (scl_fall) begin
            cnt_r <= 4'h0;
            if (st_r == S_AACK && rw_r) begin
              tx_r <= rd_byte;
              sda_oe_r <= !rd_byte[7];
              st_r <= S_RDAT;
            end else begin
              sda_oe_r <= 1'b0;
              st_r <= (st_r == S_AACK) ? S_WORD : S_WDAT;
            end
          end
        end
        S_DACK: begin
          if (scl_rise) begin
            ptr_r <= ptr_r + 6'h01;
          end else if (scl_fall) begin
            sda_oe_r <= 1'b0;
            cnt_r <= 4'h0;
            st_r <= S_WDAT;
          end
        end
        S_RDAT: begin
          if (scl_rise) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == 4'h8) begin
              sda_oe_r <= 1'b0;
              st_r <= S_RACK;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe_r <= !tx_r[6];
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            if (!sda_q2) begin
              ptr_r <= ptr_r + 6'h01;
              st_r <= S_RNXT;
            end else begin
              st_r <= S_WAIT;
            end
          end
        end
        S_RNXT: begin
          if (scl_fall) begin
            tx_r <= rd_byte;
            sda_oe_r <= !rd_byte[7];
            cnt_r <= 4'h0;
            st_r <= S_RDAT;
          end
        end
        S_IDLE, S_WAIT: begin
          sda_oe_r <= 1'b0;
        end
        default: begin
          st_r <= S_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // live bcd counters
  always_comb begin
    {c0, h_n} = bcd_inc(lv_hund, `SRTC_SUB_MAX, 8'h00);
    {c1, s_n} = bcd_inc({1'b0, lv_sec[6:0]}, `SRTC_MIN_MAX, 8'h00);
    {c2, m_n} = bcd_inc({1'b0, lv_min[6:0]}, `SRTC_MIN_MAX, 8'h00);
    {c3, hr_n} = bcd_inc({2'b00, lv_hour[5:0]}, `SRTC_HOUR_MAX, 8'h00);
    wd_n = 8'(bcd_inc({5'h00, lv_wday[2:0]}, `SRTC_WDAY_MAX, `SRTC_ONE));
    {c4, dt_n} = bcd_inc({2'b00, lv_date[5:0]},
                         month_days(lv_mon[4:0], lv_year), `SRTC_ONE);
    {c5, mo_n} = bcd_inc({3'h0, lv_mon[4:0]}, `SRTC_MON_MAX, `SRTC_ONE);
    {c6, yr_n} = bcd_inc(lv_year, `SRTC_YEAR_MAX, 8'h00);
    cent_w = c3 && c4 && c5 && c6 && lv_hour[`SRTC_CEN_EN_BIT];
    live_w[0] = lv_hund;
    live_w[1] = lv_sec;
    live_w[2] = lv_min;
    live_w[3] = lv_hour;
    live_w[4] = lv_wday;
    live_w[5] = lv_date;
    live_w[6] = lv_mon;
    live_w[7] = lv_year;
  end

  // a bus write wins over a tick landing in the same cycle
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {lv_hund, lv_sec, lv_min, lv_hour} <= 32'h0;
      {lv_wday, lv_date, lv_mon, lv_year} <= 32'h01010100;
    end else if (wr_en && ptr_r <= `SRTC_A_CLK_LAST) begin
      lv_hund <= 8'h00;
      case (ptr_r[2:0])
        3'h1: lv_sec <= sh_r;
        3'h2: lv_min <= sh_r;
        3'h3: lv_hour <= sh_r;
        3'h4: lv_wday <= sh_r;
        3'h5: lv_date <= sh_r;
        3'h6: lv_mon <= sh_r;
        3'h7: lv_year <= sh_r;
        default: lv_hund <= 8'h00;
      endcase
    end else if (tick && !lv_sec[`SRTC_HALT_BIT]) begin
      lv_hund <= h_n;
      if (c0) begin
        lv_sec <= {lv_sec[7], s_n[6:0]};
      end
      if (c0 && c1) begin
        lv_min <= {lv_min[7], m_n[6:0]};
      end
      if (c0 && c1 && c2) begin
        lv_hour <= {lv_hour[7], lv_hour[`SRTC_CEN_BIT] ^ cent_w, hr_n[5:0]};
      end
      if (c0 && c1 && c2 && c3) begin
        lv_wday <= {lv_wday[7:3], wd_n[2:0]};
        lv_date <= {lv_date[7:6], dt_n[5:0]};
      end
      if (c0 && c1 && c2 && c3 && c4) begin
        lv_mon <= {lv_mon[7:5], mo_n[4:0]};
      end
      if (c0 && c1 && c2 && c3 && c4 && c5) begin
        lv_year <= yr_n;
      end
    end
  end

  // register space; later assignments take priority
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < `SRTC_MEM_WORDS; i++) begin
        mem_r[i] <= 8'h00;
      end
    end else begin
      if (copy_en) begin
        for (int i = 0; i < 8; i++) begin
          mem_r[i] <= live_w[i];
        end
      end
      if (wr_en) begin
        mem_r[ptr_r] <= (ptr_r == `SRTC_A_SUB) ? 8'h00 : sh_r;
        if (ptr_r <= `SRTC_A_CLK_LAST) begin
          mem_r[0] <= 8'h00;
        end
      end
      if (pf_rise) begin
        mem_r[`SRTC_A_HT][`SRTC_HT_BIT] <= 1'b1;
      end
    end
  end

  assign sda_o = sda_lo_r;
  assign sda_oe_o = sda_oe_r;
  assign rst_n_o = rst_n_r;
  assign rst_oe_o = rst_oe_r;
  assign bus_state_o = st_r;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  addr_ack_a: assert property (
    (st_r == S_ADDR) && scl_fall && cnt_r == 4'h8 && sh_r[7:1] == `SRTC_SLAVE_ADDR
    && !desel && !stop_w && !start_w && !bat_s |=> sda_oe_r && st_r == S_AACK)
    else $error("address byte not acknowledged");
  ptr_load_a: assert property (
    (st_r == S_WORD) && scl_fall && cnt_r == 4'h8 && !desel && !stop_w && !start_w
    |=> ptr_r == $past(sh_r[5:0]))
    else $error("word address not loaded");
  read_inc_a: assert property (
    (st_r == S_RACK) && scl_rise && !sda_q2 && !desel && !stop_w && !start_w
    |=> ptr_r == $past(ptr_r) + 6'h01 && st_r == S_RNXT)
    else $error("pointer not advanced on read acknowledge");
  write_inc_a: assert property (
    (st_r == S_DACK) && scl_rise && !desel && !stop_w && !start_w
    |=> ptr_r == $past(ptr_r) + 6'h01)
    else $error("pointer not advanced on write acknowledge");
  freeze_copy_a: assert property (
    in_xfer_r && ptr_r <= `SRTC_A_CLK_LAST && !wr_en |=> mem_r[1] == $past(mem_r[1]))
    else $error("user time changed while frozen");
  sub_clear_a: assert property (
    wr_en && ptr_r <= `SRTC_A_CLK_LAST |=> lv_hund == 8'h00 && mem_r[0] == 8'h00)
    else $error("sub-seconds not cleared on clock write");
  pf_abort_a: assert property (
    pf_s |=> st_r == S_IDLE && ptr_r == 6'h00 && !sda_oe_r)
    else $error("bus access not aborted on power fail");
  rst_hold_a: assert property (
    $fell(pf_s) |-> ##1 (!rst_n_r && rst_oe_r == !bat_s) [*8])
    else $error("reset released during deselect interval");
  ht_set_a: assert property (
    pf_rise |=> mem_r[`SRTC_A_HT][`SRTC_HT_BIT])
    else $error("freeze bit not set on power fail");
  battery_hiz_a: assert property (
    bat_s |=> !sda_oe_r && !rst_oe_r)
    else $error("output driven on battery");

  write_seen_c: cover property (st_r == S_DACK && scl_rise);
  read_seen_c: cover property (st_r == S_RACK && scl_rise && !sda_q2);
  pfail_seen_c: cover property (pf_rise);
  century_seen_c: cover property (tick && c0 && c1 && c2 && cent_w);
endmodule : srtc_top

// ---- verif/srtc_bus_master.sv ----
// two-wire bus master model that drives the rtc bus pins
// assumes a pulled-up data wire that the device can only pull low
module srtc_bus_master (
  // clock
  input wire logic clk_i,
  // device side
  input wire logic dev_sda_i,
  input wire logic dev_oe_i,
  // bus lines
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PH = 10;
  logic m_sda;
  initial begin
    scl_o = 1'b1;
    m_sda = 1'b1;
  end
  // wired-and: a released line floats high through the pull-up
  assign sda_o = (dev_oe_i === 1'b1) ? (m_sda & dev_sda_i) : m_sda;
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask : hold
  // start, also used as repeated start from a low clock
  task automatic st();
    m_sda <= 1'b1;
    hold(PH);
    scl_o <= 1'b1;
    hold(PH);
    m_sda <= 1'b0;
    hold(PH);
    scl_o <= 1'b0;
    hold(PH);
  endtask : st
  task automatic sp();
    m_sda <= 1'b0;
    hold(PH);
    scl_o <= 1'b1;
    hold(PH);
    m_sda <= 1'b1;
    hold(PH * 4);
  endtask : sp
  task automatic clk_bit(input logic b, output logic s);
    m_sda <= b;
    hold(PH);
    scl_o <= 1'b1;
    hold(PH / 2);
    @(negedge clk_i) s = sda_o;
    hold(PH / 2);
    scl_o <= 1'b0;
    hold(2);
  endtask : clk_bit
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : wbyte
  task automatic rbyte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
    clk_bit(~mack, s);
  endtask : rbyte
endmodule : srtc_bus_master

// ---- verif/tb_srtc_top.sv ----
// self-checking bench of the serial rtc front end against a byte-level model
// assumes the bus master model drives the pins; shortened deselect and tick counts
`include "srtc_params.svh"
module tb_srtc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import srtc_pkg::*;
  localparam int REC = 20;
  localparam logic [7:0] AW = {`SRTC_SLAVE_ADDR, 1'b0};
  logic sys_clk_i = 1'b0;
  logic osc_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic pfail_i = 1'b0;
  logic batt_i = 1'b0;
  logic scl, sda, sda_o, sda_oe_o, rst_n_o, rst_oe_o;
  srtc_state_e bus_state_o;
  int error_cnt = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h6169985a;
  logic [7:0] mem [64];
  logic [7:0] got [$];
  logic [7:0] wq [$];
  int ptr = 0;
  logic ak;
  always #20 sys_clk_i = ~sys_clk_i;
  initial begin
    #7;
    forever #16 osc_clk_i = ~osc_clk_i;
  end
  srtc_top #(.REC_CYCLES(REC), .TICK_DIV(16'h0002)) srtc_top_inst (
    .sys_clk_i(sys_clk_i), .osc_clk_i(osc_clk_i), .rstn_i(rstn_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .pfail_i(pfail_i), .batt_i(batt_i), .rst_n_o(rst_n_o),
    .rst_oe_o(rst_oe_o), .bus_state_o(bus_state_o)
  );
  srtc_bus_master mst (
    .clk_i(sys_clk_i), .dev_sda_i(sda_o), .dev_oe_i(sda_oe_o),
    .scl_o(scl), .sda_o(sda)
  );
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask : chk1
  task automatic report_and_stop();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  // writes the bytes queued in wq from word address a on
  task automatic wr(input logic [7:0] a);
    mst.st();
    mst.wbyte(AW, ak);
    chk1(ak, 1'b1);
    mst.wbyte(a, ak);
    chk1(ak, 1'b1);
    ptr = a[5:0];
    foreach (wq[i]) begin
      mst.wbyte(wq[i], ak);
      chk1(ak, 1'b1);
      mem[ptr] = (ptr == 0) ? 8'h00 : wq[i];
      if (ptr <= 7) mem[0] = 8'h00;
      ptr = (ptr + 1) % 64;
    end
    mst.sp();
  endtask : wr
  // a below zero reads from the pointer as it stands
  task automatic rd(input int a, input int n, input logic ck);
    logic [7:0] b;
    got.delete();
    mst.st();
    if (a >= 0) begin
      mst.wbyte(AW, ak);
      mst.wbyte(a[7:0], ak);
      ptr = a % 64;
      mst.st();
    end
    mst.wbyte(AW | 8'h01, ak);
    chk1(ak, 1'b1);
    for (int i = 0; i < n; i++) begin
      mst.rbyte(i < n - 1, b);
      got.push_back(b);
      if (ck) chk8(b, mem[ptr]);
      if (i < n - 1) ptr = (ptr + 1) % 64;
    end
    mst.sp();
  endtask : rd
  initial begin
    #3000000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (20) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    chk1(rst_n_o, 1'b1);
    chk8(8'(bus_state_o), 8'(S_IDLE));
    wq = {rnd()};
    wr(8'h28);
    wq = {rnd(), rnd(), rnd(), rnd()};
    wr(8'h24);
    rd(-1, 2, 1'b1);
    rd(8'h24, 6, 1'b1);
    wq = {rnd()};
    wr(8'hff);
    rd(8'h3f, 1, 1'b1);
    wq = {rnd()};
    wr(8'h08);
    rd(8'h08, 1, 1'b1);
    // a foreign address must be left alone
    mst.st();
    mst.wbyte(8'ha0, ak);
    chk1(ak, 1'b0);
    mst.sp();
    pfail_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    chk1(rst_n_o, 1'b0);
    chk1(rst_oe_o, 1'b1);
    mst.st();
    mst.wbyte(AW, ak);
    chk1(ak, 1'b0);
    mst.sp();
    batt_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    chk1(rst_oe_o, 1'b0);
    chk1(sda_oe_o, 1'b0);
    batt_i <= 1'b0;
    pfail_i <= 1'b0;
    repeat (REC / 2) @(posedge sys_clk_i);
    chk1(rst_n_o, 1'b0);
    repeat (REC + 10) @(posedge sys_clk_i);
    chk1(rst_n_o, 1'b1);
    mem[`SRTC_A_HT][`SRTC_HT_BIT] = 1'b1;
    rd({2'b00, `SRTC_A_HT}, 1, 1'b1);
    wq = {8'h37, 8'h45};
    wr(8'h00);
    repeat (400) @(posedge sys_clk_i);
    rd(8'h00, 2, 1'b1);
    wq = {8'h00};
    wr({2'b00, `SRTC_A_HT});
    repeat (2000) @(posedge sys_clk_i);
    rd(8'h01, 1, 1'b0);
    chk1(got[0] != 8'h45, 1'b1);
    chk1(got[0][3:0] < 4'ha, 1'b1);
    wq = {8'h90};
    wr(8'h01);
    repeat (2000) @(posedge sys_clk_i);
    rd(8'h00, 2, 1'b1);
    wq = {8'h00};
    wr(8'h01);
    repeat (2000) @(posedge sys_clk_i);
    rd(8'h01, 1, 1'b0);
    chk1(got[0] != 8'h00, 1'b1);
    // last second of a century with the toggle enabled; seconds go last so no early carry
    wq = {8'h59, 8'ha3, 8'h07, 8'h31, 8'h12, 8'h99};
    wr(8'h02);
    wq = {8'h59};
    wr(8'h01);
    repeat (300) @(posedge sys_clk_i);
    rd(8'h03, 5, 1'b0);
    chk8(got[0], 8'hc0);
    chk8(got[1], 8'h01);
    chk8(got[2], 8'h01);
    chk8(got[3], 8'h01);
    chk8(got[4], 8'h00);
    report_and_stop();
  end
endmodule : tb_srtc_top
